//--- iudbh_pkg.sv
// constants and types of the ultra dma drive-side burst engine
package iudbh_pkg;
  localparam int DATA_W = 16;
  localparam int IDX_W = 9;
  localparam int MEM_AW = 8;
  localparam int CNT_W = 5;
  // own apb register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CRC = 8'h0c;
  localparam logic [7:0] OFF_BUFPTR = 8'h10;
  localparam logic [7:0] OFF_BUFDATA = 8'h14;
  localparam int CTRL_START = 0;
  localparam int CTRL_TOHOST = 1;
  localparam int CTRL_ABORT = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CRCERR = 2;
  localparam int ST_HOSTEND = 3;
  localparam int ST_WORDS_LO = 16;
  localparam int CRC_RX_LO = 16;
  localparam logic [IDX_W-1:0] COUNT_RESET = 9'h001;
  // map of the host controller timing registers, driven from its own side
  localparam logic [7:0] HOST_TIM_C0D0 = 8'h24;
  localparam logic [7:0] HOST_TIM_C0D1 = 8'h2c;
  localparam logic [7:0] HOST_TIM_C1D0 = 8'h34;
  localparam logic [7:0] HOST_TIM_C1D1 = 8'h3c;
  localparam logic [31:0] HOST_TIM_C0D0_RST = 32'h00077771;
  localparam logic [31:0] HOST_TIM_D1_RST = 32'h00017771;
  localparam int HOST_TIM_PIOFMT = 31;
  localparam int HOST_TIM_UDMA = 20;
  // crc-16 of ultra dma: x^16+x^12+x^5+1, seeded per burst
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'h4aba;
  // sync vector layout of host pins
  localparam int PIN_STOP = 0;
  localparam int PIN_HSTRB = 1;
  localparam int PIN_DACK = 2;
  localparam int PIN_CSA = 3;
  localparam int PIN_CSB = 4;
  localparam int PIN_ADDR = 5;
  localparam int PIN_DATA = 8;
  localparam int SYNC_W = 24;
  localparam logic [2:0] ADDR_UDMA = 3'h0;
  // own strobe half period, a least time
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_HALF_NS = 120;
  localparam logic [CNT_W-1:0] STROBE_HALF_CYC =
    CNT_W'((STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_CHECK = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LOAD = 5'h01;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_REQ = 7'h02,
    S_START = 7'h04,
    S_DATA = 7'h08,
    S_WAITSTOP = 7'h10,
    S_TERM = 7'h20,
    S_END = 7'h40
  } iudbh_state_t;
endpackage

//--- iudbh_word_mem.sv
// word buffer of the drive with registered read data
`timescale 1ns/1ns
`default_nettype none
module iudbh_word_mem (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic [iudbh_pkg::MEM_AW-1:0] wrAddr,
  input wire logic [iudbh_pkg::DATA_W-1:0] wrData,
  input wire logic [iudbh_pkg::MEM_AW-1:0] rdAddr,
  output logic [iudbh_pkg::DATA_W-1:0] rdData
);
  logic [iudbh_pkg::DATA_W-1:0] mem [0:(1<<iudbh_pkg::MEM_AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

//--- iudbh_drive_engine.sv
// drive-side ultra dma burst engine with apb control
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - drive ready pin is drive strobe on reads, drive ready on writes.
// - drive raises request; host answers with ack, both selects, address zero.
// - on reads host drops STOP, asserts ready; drive sends word and strobe.
// - receiver latches data on every strobe edge, rising and falling; the drive ignores edges once idx_q reaches count_q.
// - sender pauses by holding strobe, resumes by toggling again.
// - receiver pauses by negating ready, resumes by asserting it.
// - burst is paused before any termination starts.
// - host ends with STOP; drive answers by dropping request.
// - drive ends by dropping request; host answers with STOP.
// - after termination the sender drives its strobe high.
// - host puts crc on data while releasing ack; drive latches at ack rise.
// - both sides accumulate crc over each word on a valid strobe edge.
// - drive compares host crc with its own and flags mismatch.
module iudbh_drive_engine (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic disk_write_strobe_n,
  input wire logic disk_read_strobe_n,
  input wire logic disk_dma_ack_n,
  input wire logic disk_select_a_n,
  input wire logic disk_select_b_n,
  input wire logic [2:0] disk_addr_lines,
  input wire logic [15:0] disk_data_bus_in,
  output logic [15:0] disk_data_bus_out,
  output logic disk_data_bus_oe,
  output logic disk_dma_request,
  output logic disk_ready_in
);
  localparam int DW = iudbh_pkg::DATA_W;
  localparam int IW = iudbh_pkg::IDX_W;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [15:0] crcWord(input logic [15:0] c,
                                          input logic [15:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ iudbh_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  iudbh_pkg::iudbh_state_t state_q;
  logic [iudbh_pkg::SYNC_W-1:0] pinS1_q, pinS2_q;
  logic hstrbPrev_q, dackPrev_q;
  logic [IW-1:0] idx_q, count_q;
  logic [iudbh_pkg::CNT_W-1:0] cnt_q;
  logic [iudbh_pkg::MEM_AW-1:0] ptr_q;
  logic [15:0] crc_q, crcRx_q, dataOut_q;
  logic dreq_q, line_q, oe_q, toHost_q, abort_q;
  logic done_q, crcErr_q, hostEnd_q, rdWait_q;
  logic [31:0] prdata_q, readMux;
  logic stopOn, hostRdyN, dackN, selOk, hstrbEdge, dackRise;
  logic [DW-1:0] dataS, memRd, memWd;
  logic access, isBufData, complete, mapped, startPulse;
  logic capture, readToggle, endSeen, memWe;
  logic [iudbh_pkg::MEM_AW-1:0] memWa, memRa;

  // host pins are asynchronous; data shares the strobe's sync depth
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // reset to idle pin levels so no false strobe or ack edge follows
      pinS1_q <= '1;
      pinS2_q <= '1;
      hstrbPrev_q <= 1'b1;
      dackPrev_q <= 1'b1;
    end else begin
      pinS1_q <= {disk_data_bus_in, disk_addr_lines, disk_select_b_n,
                  disk_select_a_n, disk_dma_ack_n, disk_read_strobe_n,
                  disk_write_strobe_n};
      pinS2_q <= pinS1_q;
      hstrbPrev_q <= pinS2_q[iudbh_pkg::PIN_HSTRB];
      dackPrev_q <= pinS2_q[iudbh_pkg::PIN_DACK];
    end
  end

  assign stopOn = pinS2_q[iudbh_pkg::PIN_STOP];
  assign hostRdyN = pinS2_q[iudbh_pkg::PIN_HSTRB];
  assign dackN = pinS2_q[iudbh_pkg::PIN_DACK];
  assign selOk = !pinS2_q[iudbh_pkg::PIN_CSA] &&
                 !pinS2_q[iudbh_pkg::PIN_CSB] &&
                 pinS2_q[iudbh_pkg::PIN_ADDR +: 3] == iudbh_pkg::ADDR_UDMA;
  assign dataS = pinS2_q[iudbh_pkg::PIN_DATA +: DW];
  assign hstrbEdge = pinS2_q[iudbh_pkg::PIN_HSTRB] ^ hstrbPrev_q;
  assign dackRise = dackN & ~dackPrev_q;

  // apb slave
  assign access = psel & penable;
  assign isBufData = hit(paddr, iudbh_pkg::OFF_BUFDATA);
  assign mapped = hit(paddr, iudbh_pkg::OFF_CTRL) ||
                  hit(paddr, iudbh_pkg::OFF_COUNT) ||
                  hit(paddr, iudbh_pkg::OFF_STATUS) ||
                  hit(paddr, iudbh_pkg::OFF_CRC) ||
                  hit(paddr, iudbh_pkg::OFF_BUFPTR) || isBufData;
  // buffer reads take one wait so the registered memory can catch up
  assign pready = ~(isBufData & ~pwrite) | rdWait_q;
  assign pslverr = access & (~mapped | (isBufData & state_q !=
                   iudbh_pkg::S_IDLE));
  assign complete = access & pready;
  assign prdata = prdata_q;
  assign startPulse = complete & pwrite & hit(paddr, iudbh_pkg::OFF_CTRL) &
                      pwdata[iudbh_pkg::CTRL_START] &
                      state_q == iudbh_pkg::S_IDLE;

  always_comb begin
    readMux = '0;
    if (hit(paddr, iudbh_pkg::OFF_CTRL)) begin
      readMux[iudbh_pkg::CTRL_TOHOST] = toHost_q;
      readMux[iudbh_pkg::CTRL_ABORT] = abort_q;
    end else if (hit(paddr, iudbh_pkg::OFF_COUNT)) begin
      readMux[IW-1:0] = count_q;
    end else if (hit(paddr, iudbh_pkg::OFF_STATUS)) begin
      readMux[iudbh_pkg::ST_BUSY] = state_q != iudbh_pkg::S_IDLE;
      readMux[iudbh_pkg::ST_DONE] = done_q;
      readMux[iudbh_pkg::ST_CRCERR] = crcErr_q;
      readMux[iudbh_pkg::ST_HOSTEND] = hostEnd_q;
      readMux[iudbh_pkg::ST_WORDS_LO +: IW] = idx_q;
    end else if (hit(paddr, iudbh_pkg::OFF_CRC)) begin
      readMux = {crcRx_q, crc_q};
    end else if (hit(paddr, iudbh_pkg::OFF_BUFPTR)) begin
      readMux[iudbh_pkg::MEM_AW-1:0] = ptr_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= '0;
      rdWait_q <= 1'b0;
    end else begin
      rdWait_q <= access & isBufData & ~pwrite & ~rdWait_q;
      if (psel & ~penable) begin
        prdata_q <= readMux;
      end else if (access & isBufData & ~pwrite & ~rdWait_q) begin
        prdata_q <= {16'h0000, memRd};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_q <= iudbh_pkg::COUNT_RESET;
      ptr_q <= '0;
      toHost_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      if (complete & pwrite & state_q == iudbh_pkg::S_IDLE) begin
        if (hit(paddr, iudbh_pkg::OFF_COUNT)) begin
          count_q <= pwdata[IW-1:0];
        end
        if (hit(paddr, iudbh_pkg::OFF_CTRL)) begin
          toHost_q <= pwdata[iudbh_pkg::CTRL_TOHOST];
        end
        if (hit(paddr, iudbh_pkg::OFF_BUFPTR)) begin
          ptr_q <= pwdata[iudbh_pkg::MEM_AW-1:0];
        end
      end
      if (complete & isBufData & state_q == iudbh_pkg::S_IDLE) begin
        ptr_q <= ptr_q + 1'b1;
      end
      if (state_q == iudbh_pkg::S_IDLE) begin
        abort_q <= 1'b0;
      end else if (complete & pwrite & hit(paddr, iudbh_pkg::OFF_CTRL)) begin
        abort_q <= abort_q | pwdata[iudbh_pkg::CTRL_ABORT];
      end
    end
  end

  assign capture = state_q == iudbh_pkg::S_DATA && !toHost_q && hstrbEdge &&
                   idx_q < count_q;
  assign readToggle = state_q == iudbh_pkg::S_DATA && toHost_q &&
                      cnt_q == iudbh_pkg::STROBE_HALF_CYC;
  assign endSeen = state_q == iudbh_pkg::S_END && dackRise;
  assign memWe = capture | (complete & pwrite & isBufData &
                 state_q == iudbh_pkg::S_IDLE);
  assign memWa = capture ? idx_q[iudbh_pkg::MEM_AW-1:0] : ptr_q;
  assign memWd = capture ? dataS : pwdata[DW-1:0];
  assign memRa = state_q == iudbh_pkg::S_IDLE ? ptr_q :
                 idx_q[iudbh_pkg::MEM_AW-1:0];

  iudbh_word_mem uMem (
    .clk_sys(clk_sys),
    .wrEn(memWe),
    .wrAddr(memWa),
    .wrData(memWd),
    .rdAddr(memRa),
    .rdData(memRd)
  );

  // burst sequencing and link pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= iudbh_pkg::S_IDLE;
      idx_q <= '0;
      cnt_q <= '0;
      dreq_q <= 1'b0;
      line_q <= 1'b1;
      oe_q <= 1'b0;
      dataOut_q <= '0;
    end else begin
      unique case (state_q)
        iudbh_pkg::S_IDLE: begin
          if (startPulse) begin
            state_q <= iudbh_pkg::S_REQ;
            dreq_q <= 1'b1;
            idx_q <= '0;
            cnt_q <= iudbh_pkg::CNT_CHECK;
          end
        end
        iudbh_pkg::S_REQ: begin
          if (!dackN && selOk) begin
            state_q <= iudbh_pkg::S_START;
          end else if (abort_q) begin
            dreq_q <= 1'b0;
            state_q <= iudbh_pkg::S_IDLE;
          end
        end
        iudbh_pkg::S_START: begin
          if (!stopOn && (!toHost_q || !hostRdyN)) begin
            state_q <= iudbh_pkg::S_DATA;
          end
        end
        iudbh_pkg::S_DATA: begin
          if (toHost_q) begin
            if (cnt_q == iudbh_pkg::CNT_CHECK) begin
              if (stopOn) begin
                state_q <= iudbh_pkg::S_TERM;
              end else if (idx_q == count_q || abort_q) begin
                dreq_q <= 1'b0;
                state_q <= iudbh_pkg::S_WAITSTOP;
              end else if (!hostRdyN) begin
                cnt_q <= iudbh_pkg::CNT_LOAD;
              end
            end else if (cnt_q == iudbh_pkg::CNT_LOAD) begin
              dataOut_q <= memRd;
              oe_q <= 1'b1;
              cnt_q <= cnt_q + 1'b1;
            end else if (readToggle) begin
              line_q <= ~line_q;
              idx_q <= idx_q + 1'b1;
              cnt_q <= iudbh_pkg::CNT_CHECK;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else begin
            // receiver pause: ready drops once the buffer quota is met
            line_q <= !(idx_q < count_q && !abort_q);
            if (capture) begin
              idx_q <= idx_q + 1'b1;
            end
            if (stopOn) begin
              state_q <= iudbh_pkg::S_TERM;
            end else if (line_q && (idx_q == count_q || abort_q)) begin
              dreq_q <= 1'b0;
              state_q <= iudbh_pkg::S_WAITSTOP;
            end
          end
        end
        iudbh_pkg::S_WAITSTOP: begin
          if (stopOn) begin
            state_q <= iudbh_pkg::S_END;
          end
        end
        iudbh_pkg::S_TERM: begin
          dreq_q <= 1'b0;
          state_q <= iudbh_pkg::S_END;
        end
        iudbh_pkg::S_END: begin
          line_q <= 1'b1;
          oe_q <= 1'b0;
          if (dackRise) begin
            state_q <= iudbh_pkg::S_IDLE;
          end
        end
        default: begin
          state_q <= iudbh_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      crc_q <= iudbh_pkg::CRC_SEED;
    end else if (startPulse) begin
      crc_q <= iudbh_pkg::CRC_SEED;
    end else if (readToggle) begin
      crc_q <= crcWord(crc_q, dataOut_q);
    end else if (capture) begin
      crc_q <= crcWord(crc_q, dataS);
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'b0;
      crcErr_q <= 1'b0;
      hostEnd_q <= 1'b0;
      crcRx_q <= '0;
    end else begin
      if (endSeen) begin
        crcRx_q <= dataS;
      end
      if (complete & pwrite & hit(paddr, iudbh_pkg::OFF_STATUS)) begin
        done_q <= done_q & ~pwdata[iudbh_pkg::ST_DONE];
        crcErr_q <= crcErr_q & ~pwdata[iudbh_pkg::ST_CRCERR];
        hostEnd_q <= hostEnd_q & ~pwdata[iudbh_pkg::ST_HOSTEND];
      end
      if (endSeen) begin
        done_q <= 1'b1;
      end
      if (endSeen && dataS != crc_q) begin
        crcErr_q <= 1'b1;
      end
      if (state_q == iudbh_pkg::S_TERM) begin
        hostEnd_q <= 1'b1;
      end
    end
  end

  assign disk_dma_request = dreq_q;
  assign disk_ready_in = line_q;
  assign disk_data_bus_out = dataOut_q;
  assign disk_data_bus_oe = oe_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seqPausedHostStop;
    state_q == iudbh_pkg::S_DATA && cnt_q == iudbh_pkg::CNT_CHECK && stopOn;
  endsequence
  sequence seqDropReq;
    state_q == iudbh_pkg::S_TERM ##1 !dreq_q;
  endsequence

  AST_REQ_ON_START: assert property (
    startPulse |=> dreq_q && state_q == iudbh_pkg::S_REQ)
    else $error("request not raised after start");
  AST_HOST_END: assert property (
    seqPausedHostStop |=> seqDropReq)
    else $error("host stop not answered by dropping request");
  AST_DRIVE_END: assert property (
    state_q == iudbh_pkg::S_WAITSTOP |-> !dreq_q && $stable(line_q))
    else $error("drive termination with request or strobe moving");
  AST_NO_DRIVE_ON_WRITE: assert property (
    !toHost_q && state_q != iudbh_pkg::S_IDLE |-> !oe_q)
    else $error("drive drives data during host write");
  AST_DATA_STABLE_AT_EDGE: assert property (
    readToggle |-> ##1 $changed(line_q) && $stable(dataOut_q) && oe_q)
    else $error("data not stable across drive strobe edge");
  AST_CRC_ACCUM: assert property (
    readToggle |=> crc_q == crcWord($past(crc_q), $past(dataOut_q)))
    else $error("crc not advanced on strobe edge");
  AST_PAUSE_HOLD: assert property (
    toHost_q && state_q == iudbh_pkg::S_DATA &&
    cnt_q == iudbh_pkg::CNT_CHECK && hostRdyN && !stopOn |=>
    $stable(line_q) [*2])
    else $error("strobe toggled while host not ready");
  AST_RECV_PAUSE: assert property (
    !toHost_q && state_q == iudbh_pkg::S_DATA && idx_q == count_q |=>
    line_q)
    else $error("ready still asserted with buffer quota met");
  AST_STROBE_HIGH: assert property (
    state_q == iudbh_pkg::S_END |=> line_q && !oe_q)
    else $error("strobe not high or bus held at burst end");
  AST_CRC_CHECK: assert property (
    endSeen |=> crcRx_q == $past(dataS) && done_q &&
    ($past(dataS) == $past(crc_q) || crcErr_q))
    else $error("host crc not captured or compared at ack rise");
  AST_TERM_PAUSED: assert property (
    state_q == iudbh_pkg::S_DATA ##1 state_q == iudbh_pkg::S_WAITSTOP |->
    $stable(line_q))
    else $error("termination began while strobe moving");
endmodule
`default_nettype wire

//--- iudbh_host_model.sv
// host-side partner model that drives the ultra dma link
`timescale 1ns/1ns
`default_nettype none
module iudbh_host_model #(
  // reset image of channel 1 drive 0 is unknown; plain default
  parameter logic [31:0] C1D0_RST = 32'h00000000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic dmaRequest,
  input wire logic driveStrobe,
  input wire logic [15:0] busIn,
  output logic stopPin,
  output logic hostStrobe,
  output logic ackN,
  output logic selAN,
  output logic selBN,
  output logic [2:0] addrLines,
  output logic [15:0] hostData,
  output logic hostOe
);
  logic [31:0] timingQ [4];
  // timing is only held here and used by nothing, so the drive never reads it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timingQ[0] <= iudbh_pkg::HOST_TIM_C0D0_RST;
      timingQ[1] <= iudbh_pkg::HOST_TIM_D1_RST;
      timingQ[2] <= C1D0_RST;
      timingQ[3] <= iudbh_pkg::HOST_TIM_D1_RST;
    end
  end
  initial begin
    stopPin = 1'b1;
    hostStrobe = 1'b1;
    ackN = 1'b1;
    selAN = 1'b1;
    selBN = 1'b1;
    addrLines = 3'h7;
    hostData = 16'h0000;
    hostOe = 1'b0;
  end
  task automatic startup(input logic toHost, input logic rdy);
    while (dmaRequest !== 1'b1) @(posedge clk_sys);
    ackN <= 1'b0;
    selAN <= 1'b0;
    selBN <= 1'b0;
    addrLines <= iudbh_pkg::ADDR_UDMA;
    @(posedge clk_sys);
    stopPin <= 1'b0;
    if (toHost && rdy) hostStrobe <= 1'b0;
  endtask
  task automatic sendWord(input logic [15:0] w);
    while (driveStrobe !== 1'b0) @(posedge clk_sys);
    hostData <= w;
    hostOe <= 1'b1;
    repeat (2) @(posedge clk_sys);
    hostStrobe <= ~hostStrobe;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic setReady(input logic rdy);
    hostStrobe <= ~rdy;
  endtask
  task automatic setStop();
    stopPin <= 1'b1;
  endtask
  task automatic recvWord(output logic [15:0] w);
    logic last;
    last = driveStrobe;
    while (driveStrobe === last) @(posedge clk_sys);
    w = busIn;
  endtask
  task automatic finish(input logic [15:0] crc);
    hostStrobe <= 1'b1;
    @(posedge clk_sys);
    hostData <= crc;
    hostOe <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ackN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    hostOe <= 1'b0;
    selAN <= 1'b1;
    selBN <= 1'b1;
    addrLines <= 3'h7;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench of the drive engine against the host model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, stopPin, hostStrobe, ackN, selAN, selBN;
  logic [2:0] addrLines;
  logic [15:0] hostData, driveOut, busIn;
  logic [15:0] floatQ = 16'h5a5a;
  logic hostOe, driveOe, dmaRequest, driveReady;
  int err_total = 0;
  int tests_run = 0;
  // nobody drives: the bus shows a changing pattern, not stale data
  assign busIn = driveOe ? driveOut : (hostOe ? hostData : floatQ);
  always @(posedge clk_sys) if (!rst) floatQ <= ~busIn;
  iudbh_drive_engine u_iudbh_drive_engine (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .disk_write_strobe_n(stopPin), .disk_read_strobe_n(hostStrobe),
    .disk_dma_ack_n(ackN), .disk_select_a_n(selAN),
    .disk_select_b_n(selBN), .disk_addr_lines(addrLines),
    .disk_data_bus_in(busIn), .disk_data_bus_out(driveOut),
    .disk_data_bus_oe(driveOe), .disk_dma_request(dmaRequest),
    .disk_ready_in(driveReady));
  iudbh_host_model u_iudbh_host_model (.clk_sys(clk_sys), .rst(rst),
    .dmaRequest(dmaRequest), .driveStrobe(driveReady), .busIn(busIn),
    .stopPin(stopPin), .hostStrobe(hostStrobe), .ackN(ackN),
    .selAN(selAN), .selBN(selBN), .addrLines(addrLines),
    .hostData(hostData), .hostOe(hostOe));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
  endtask
  task automatic waitReqLow();
    int k = 0;
    while (dmaRequest !== 1'b0 && k < 60) begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  // bit-serial, msb first, as the drive does it
  function automatic logic [15:0] crcNext(input logic [15:0] c,
                                          input logic [15:0] d);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0};
      if (fb) c = c ^ iudbh_pkg::CRC_POLY;
    end
    return c;
  endfunction
  function automatic logic [15:0] pat(input int i, input logic [15:0] b);
    return b + 16'(i) * 16'h0f3c;
  endfunction
  task automatic writeBurst(input int n, input int nSend,
                            input logic hostEnds, input logic badCrc);
    logic [15:0] crc, sent;
    logic [31:0] q;
    logic e;
    crc = iudbh_pkg::CRC_SEED;
    wr(iudbh_pkg::OFF_COUNT, 32'(n));
    wr(iudbh_pkg::OFF_BUFPTR, 32'h0);
    wr(iudbh_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, iudbh_pkg::OFF_BUFDATA, 32'h0, q, e);
    chk("busy bufdata refused", 32'h1, 32'(e));
    u_iudbh_host_model.startup(1'b0, 1'b1);
    for (int i = 0; i < nSend; i++) begin
      u_iudbh_host_model.sendWord(pat(i, 16'ha5c3));
      crc = crcNext(crc, pat(i, 16'ha5c3));
    end
    if (!hostEnds && nSend < n) wr(iudbh_pkg::OFF_CTRL, 32'h4);
    if (hostEnds) u_iudbh_host_model.setStop();
    waitReqLow();
    chk("request dropped", 32'h0, 32'(dmaRequest));
    if (!hostEnds) chk("drive paused", 32'h1, 32'(driveReady));
    if (!hostEnds) u_iudbh_host_model.setStop();
    sent = badCrc ? ~crc : crc;
    u_iudbh_host_model.finish(sent);
    rdChk("status", iudbh_pkg::OFF_STATUS,
          {7'h0, 9'(nSend), 12'h0, hostEnds, badCrc, 2'b10});
    rdChk("crc", iudbh_pkg::OFF_CRC, {sent, crc});
    wr(iudbh_pkg::OFF_STATUS, 32'he);
    wr(iudbh_pkg::OFF_BUFPTR, 32'h0);
    for (int i = 0; i < nSend; i++)
      rdChk("word", iudbh_pkg::OFF_BUFDATA, 32'(pat(i, 16'ha5c3)));
  endtask
  task automatic readBurst(input int n);
    logic [15:0] crc, w;
    int k;
    crc = iudbh_pkg::CRC_SEED;
    wr(iudbh_pkg::OFF_BUFPTR, 32'h0);
    for (int i = 0; i < n; i++)
      wr(iudbh_pkg::OFF_BUFDATA, 32'(pat(i, 16'h3c96)));
    wr(iudbh_pkg::OFF_COUNT, 32'(n));
    wr(iudbh_pkg::OFF_CTRL, 32'h3);
    u_iudbh_host_model.startup(1'b1, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk("no strobe unready", 32'h1, 32'(driveReady));
    u_iudbh_host_model.setReady(1'b1);
    for (int i = 0; i < n; i++) begin
      u_iudbh_host_model.recvWord(w);
      chk("read word", 32'(pat(i, 16'h3c96)), 32'(w));
      crc = crcNext(crc, pat(i, 16'h3c96));
      // the word already under way still comes; the next one must wait
      if (i == 0) u_iudbh_host_model.setReady(1'b0);
      if (i == 1) begin
        repeat (30) @(posedge clk_sys);
        chk("host pause", 32'h1, 32'(driveReady));
        u_iudbh_host_model.setReady(1'b1);
      end
    end
    waitReqLow();
    chk("drive end", 32'h0, 32'(dmaRequest));
    u_iudbh_host_model.setStop();
    k = 0;
    while ((driveOe !== 1'b0 || driveReady !== 1'b1) && k < 60) begin
      @(posedge clk_sys);
      k++;
    end
    chk("strobe high", 32'h1, 32'(driveReady));
    chk("oe released", 32'h0, 32'(driveOe));
    u_iudbh_host_model.finish(crc);
    rdChk("status rd", iudbh_pkg::OFF_STATUS,
          {7'h0, 9'(n), 12'h0, 4'b0010});
    rdChk("crc rd", iudbh_pkg::OFF_CRC, {crc, crc});
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    final_report();
  end
  initial begin
    logic [31:0] q;
    logic e;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk("request idle", 32'h0, 32'(dmaRequest));
    chk("ready idle", 32'h1, 32'(driveReady));
    chk("oe idle", 32'h0, 32'(driveOe));
    rdChk("count reset", iudbh_pkg::OFF_COUNT, 32'h1);
    rdChk("status reset", iudbh_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    writeBurst(3, 3, 1'b0, 1'b0);
    writeBurst(4, 2, 1'b1, 1'b0);
    writeBurst(1, 1, 1'b0, 1'b1);
    writeBurst(3, 1, 1'b0, 1'b0);
    readBurst(3);
    final_report();
  end
endmodule
`default_nettype wire
